// ---- cpu_regs_pkg.sv ----
// Constants, field positions and types for the core register set.
// Assumes a single core clock domain; shared by the register set and its bench.
package cpu_regs_pkg;

	// ==========================================================
	// Widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int SPLOW_W = 7;

	// ==========================================================
	// Condition flag bit positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_ZERO = 1;
	localparam int FLAG_NEG = 2;
	localparam int FLAG_MASK = 3;
	localparam int FLAG_HALF = 4;

	// Bits 7:5 always read as one; unknown reset flags are taken as zero.
	localparam logic [7:0] FLAGS_FIXED = 8'hE0;
	localparam logic [7:0] FLAGS_RESET = 8'hE8;

	// ==========================================================
	// Stack window: 128 bytes, upper nine address bits fixed.
	localparam logic [8:0] STACK_HI = 9'h003;
	localparam logic [6:0] STACK_TOP = 7'h7F;
	localparam logic [15:0] SP_RESET = 16'h01FF;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// ==========================================================
	// Stack usage per event and context save order (index = save step).
	localparam int CALL_BYTES = 2;
	localparam logic [2:0] CTX_BYTES = 3'h5;
	localparam logic [2:0] CTX_PCL = 3'h0;
	localparam logic [2:0] CTX_PCH = 3'h1;
	localparam logic [2:0] CTX_IDX = 3'h2;
	localparam logic [2:0] CTX_ACC = 3'h3;
	localparam logic [2:0] CTX_FLG = 3'h4;
	localparam logic [2:0] TAG_CORE = 3'h7;

	typedef enum logic [1:0] {CTX_IDLE, CTX_SAVE, CTX_RESTORE} ctx_state_t;

endpackage

// ---- cpu_register_set.sv ----
// Architectural register set of the 8-bit core: accumulator, two index
// registers, instruction counter, condition flags and stack pointer, with
// the interrupt context save and restore sequencer.
// Assumes the execution unit and stack RAM run on core_clk; RAM read data
// is valid in the cycle after memRe_r is high.
//
// Behaviour
// RQ1: One 8-bit accumulator holds operands and ALU results.
// RQ2: Two 8-bit index registers; the second is selected by a prefix.
// RQ3: Interrupt entry and return never push or pop the second index.
// RQ4: 16-bit instruction counter built from a low and a high byte.
// RQ5: Flags bits 7:5 read one; reset sets them and the mask.
// RQ6: Flags load whole from pop and have per-bit set and clear.
// RQ7: Half carry follows carry from bit 3, on add instructions only.
// RQ8: Mask set by entry or software, cleared by software or interrupt return.
// RQ9: Requests arriving while masked are held until the mask clears.
// RQ10: Interrupt return leaves the mask clear.
// RQ11: Clearing the mask in a routine lets pending requests in at once.
// RQ12: Negative flag copies result bit 7 after each data operation.
// RQ13: Zero flag is one exactly when the result is zero.
// RQ14: Carry from arithmetic, set/clear instructions, test, shift, rotate.
// RQ15: Stack pointer: decrement after push, increment before pop.
// RQ16: 128-byte stack; upper nine pointer bits fixed, low seven vary.
// RQ17: Reset or stack reset instruction loads the top address.
// RQ18: Pointer wraps at either limit silently, overwriting old data.
// RQ19: Load instruction reads and writes the pointer low byte.
// RQ20: Interrupt entry stores the counter low byte first, then lower.
// RQ21: Call uses two stack bytes, interrupt uses five.
// RQ22: Save order low, high counter, index, accumulator, flags; reverse.
`timescale 1ns/1ps
module cpu_register_set
	import cpu_regs_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic accWe,
	input wire logic [DATA_W-1:0] accIn,
	input wire logic firstIdxWe,
	input wire logic secondIdxWe,
	input wire logic [DATA_W-1:0] idxIn,
	input wire logic pcLoad,
	input wire logic pcInc,
	input wire logic [ADDR_W-1:0] pcIn,
	input wire logic flagsWe,
	input wire logic [DATA_W-1:0] flagsIn,
	input wire logic aluUpd,
	input wire logic aluIsAdd,
	input wire logic [DATA_W-1:0] aluResult,
	input wire logic aluHalf,
	input wire logic carryUpd,
	input wire logic aluCarry,
	input wire logic carrySetInstr,
	input wire logic carryClearInstr,
	input wire logic maskSetInstr,
	input wire logic maskClearInstr,
	input wire logic stackResetInstr,
	input wire logic spLowWe,
	input wire logic [DATA_W-1:0] spLowIn,
	input wire logic pushReq,
	input wire logic [DATA_W-1:0] pushData,
	input wire logic popReq,
	input wire logic irqReq,
	input wire logic trapReq,
	input wire logic intEntry,
	input wire logic intReturn,
	input wire logic [DATA_W-1:0] memRdata,
	output logic [DATA_W-1:0] workingAcc_r,
	output logic [DATA_W-1:0] firstIndex_r,
	output logic [DATA_W-1:0] secondIndex_r,
	output logic [ADDR_W-1:0] instrCounter_r,
	output logic [DATA_W-1:0] conditionFlags_r,
	output logic [ADDR_W-1:0] stackTopPointer_r,
	output logic [DATA_W-1:0] popData_r,
	output logic popValid_r,
	output logic memWe_r,
	output logic memRe_r,
	output logic [ADDR_W-1:0] memAddr_r,
	output logic [DATA_W-1:0] memWdata_r,
	output logic ctxBusy_r,
	output logic irqGrant_r
);

	// ==========================================================
	// Internal state
	ctx_state_t ctxState_r;
	logic [2:0] step_r;
	logic [2:0] rdTag_r;
	logic rdLive_r;
	logic [2:0] rdLiveTag_r;
	logic irqPend_r;
	logic trapPend_r;
	logic doPush;
	logic doPop;
	logic [DATA_W-1:0] wByte;
	logic [2:0] popTag;
	logic lastStep;
	logic saveDone;
	logic grantNow;
	logic [SPLOW_W-1:0] spLow;
	logic [SPLOW_W-1:0] spDec;
	logic [SPLOW_W-1:0] spInc;
	logic restoreHit;

	assign spLow = stackTopPointer_r[SPLOW_W-1:0];
	assign spDec = spLow - 7'h01; // RQ18
	assign spInc = spLow + 7'h01; // RQ18
	assign lastStep = (step_r == CTX_BYTES - 3'h1);
	assign saveDone = (ctxState_r == CTX_SAVE) && lastStep;
	assign restoreHit = rdLive_r && (rdLiveTag_r != TAG_CORE);

	// ==========================================================
	// Stack access selection. Context sequencing owns the stack port
	// while busy; core push and pop are honoured only when idle, and a
	// same-cycle interrupt start takes precedence over them.
	always_comb
	begin
		doPush = 1'b0;
		doPop = 1'b0;
		wByte = pushData;
		popTag = TAG_CORE;
		case (ctxState_r)
			CTX_SAVE:
			begin
				doPush = 1'b1;
				case (step_r) // RQ22
					CTX_PCL: wByte = instrCounter_r[7:0]; // RQ20
					CTX_PCH: wByte = instrCounter_r[15:8];
					CTX_IDX: wByte = firstIndex_r; // RQ3
					CTX_ACC: wByte = workingAcc_r;
					default: wByte = conditionFlags_r;
				endcase
			end
			CTX_RESTORE:
			begin
				doPop = 1'b1;
				popTag = CTX_FLG - step_r; // RQ22
			end
			CTX_IDLE:
			begin
				if (!intEntry && !intReturn)
				begin
					doPush = pushReq;
					doPop = popReq && !pushReq;
				end
			end
			default:
			begin
				doPush = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Context sequencer: five bytes out on entry, five back on return.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctxState_r <= CTX_IDLE;
			step_r <= 3'h0;
			ctxBusy_r <= 1'b0;
		end
		else
		begin
			case (ctxState_r)
				CTX_IDLE:
				begin
					step_r <= 3'h0;
					if (intEntry)
					begin
						ctxState_r <= CTX_SAVE; // RQ21
						ctxBusy_r <= 1'b1;
					end
					else if (intReturn)
					begin
						ctxState_r <= CTX_RESTORE;
						ctxBusy_r <= 1'b1;
					end
				end
				CTX_SAVE, CTX_RESTORE:
				begin
					step_r <= step_r + 3'h1;
					if (lastStep)
					begin
						ctxState_r <= CTX_IDLE;
						ctxBusy_r <= 1'b0;
					end
				end
				default:
				begin
					ctxState_r <= CTX_IDLE;
					ctxBusy_r <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Stack RAM port. Push writes at the pointer; pop reads one above.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			memWe_r <= 1'b0;
			memRe_r <= 1'b0;
			memAddr_r <= SP_RESET;
			memWdata_r <= DATA_RESET;
			rdTag_r <= TAG_CORE;
			rdLive_r <= 1'b0;
			rdLiveTag_r <= TAG_CORE;
		end
		else
		begin
			memWe_r <= doPush;
			memRe_r <= doPop;
			rdTag_r <= popTag;
			rdLive_r <= memRe_r;
			rdLiveTag_r <= rdTag_r;
			if (doPush)
			begin
				memAddr_r <= {STACK_HI, spLow}; // RQ15
				memWdata_r <= wByte;
			end
			else if (doPop)
			begin
				memAddr_r <= {STACK_HI, spInc}; // RQ15
			end
		end
	end

	// ==========================================================
	// Stack pointer. The fixed upper bits are rebuilt on every update,
	// so no write path can move the stack out of its window.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			stackTopPointer_r <= SP_RESET; // RQ17
		else if (stackResetInstr)
			stackTopPointer_r <= {STACK_HI, STACK_TOP}; // RQ17
		else if (doPush)
			stackTopPointer_r <= {STACK_HI, spDec}; // RQ15 RQ18
		else if (doPop)
			stackTopPointer_r <= {STACK_HI, spInc}; // RQ15 RQ18
		else if (spLowWe)
			stackTopPointer_r <= {STACK_HI, spLowIn[SPLOW_W-1:0]}; // RQ19 RQ16
	end

	// ==========================================================
	// Core pop result, one cycle after the RAM data is valid.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			popValid_r <= 1'b0;
			popData_r <= DATA_RESET;
		end
		else
		begin
			popValid_r <= rdLive_r && (rdLiveTag_r == TAG_CORE);
			if (rdLive_r)
				popData_r <= memRdata;
		end
	end

	// ==========================================================
	// Accumulator and index registers.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			workingAcc_r <= DATA_RESET;
			firstIndex_r <= DATA_RESET;
			secondIndex_r <= DATA_RESET;
		end
		else
		begin
			if (restoreHit && rdLiveTag_r == CTX_ACC)
				workingAcc_r <= memRdata;
			else if (accWe)
				workingAcc_r <= accIn; // RQ1
			if (restoreHit && rdLiveTag_r == CTX_IDX)
				firstIndex_r <= memRdata;
			else if (firstIdxWe)
				firstIndex_r <= idxIn; // RQ2
			// The second index has no context path at all.
			if (secondIdxWe)
				secondIndex_r <= idxIn; // RQ2 RQ3
		end
	end

	// ==========================================================
	// Instruction counter, as separate low and high bytes.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			instrCounter_r <= PC_RESET;
		else if (restoreHit && rdLiveTag_r == CTX_PCL)
			instrCounter_r[7:0] <= memRdata; // RQ4
		else if (restoreHit && rdLiveTag_r == CTX_PCH)
			instrCounter_r[15:8] <= memRdata; // RQ4
		else if (pcLoad)
			instrCounter_r <= pcIn;
		else if (pcInc)
			instrCounter_r <= instrCounter_r + 16'h0001;
	end

	// ==========================================================
	// Condition flags. A whole-register load wins over per-bit updates;
	// within the per-bit group the hardware mask set on entry is last
	// so that a software clear in the same cycle cannot undo it.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			conditionFlags_r <= FLAGS_RESET; // RQ5
		else if (restoreHit && rdLiveTag_r == CTX_FLG)
		begin
			conditionFlags_r <= memRdata | FLAGS_FIXED; // RQ6 RQ5
			conditionFlags_r[FLAG_MASK] <= 1'b0; // RQ10
		end
		else if (flagsWe)
			conditionFlags_r <= flagsIn | FLAGS_FIXED; // RQ6 RQ5
		else
		begin
			if (aluUpd)
			begin
				conditionFlags_r[FLAG_NEG] <= aluResult[7]; // RQ12
				conditionFlags_r[FLAG_ZERO] <= (aluResult == DATA_RESET); // RQ13
				if (aluIsAdd)
					conditionFlags_r[FLAG_HALF] <= aluHalf; // RQ7
			end
			if (carryUpd)
				conditionFlags_r[FLAG_CARRY] <= aluCarry; // RQ14
			if (carrySetInstr)
				conditionFlags_r[FLAG_CARRY] <= 1'b1; // RQ14 RQ6
			if (carryClearInstr)
				conditionFlags_r[FLAG_CARRY] <= 1'b0; // RQ14 RQ6
			if (maskClearInstr)
				conditionFlags_r[FLAG_MASK] <= 1'b0; // RQ8
			if (maskSetInstr || saveDone)
				conditionFlags_r[FLAG_MASK] <= 1'b1; // RQ8
		end
	end

	// ==========================================================
	// Interrupt pending and grant. Requests latch while masked and are
	// granted as soon as the mask reads clear and the sequencer is idle,
	// whatever routine runs; a pending trap is granted even while masked.
	assign grantNow = (ctxState_r == CTX_IDLE) && !irqGrant_r && !intEntry &&
		(trapPend_r || (irqPend_r && !conditionFlags_r[FLAG_MASK])); // RQ8 RQ11

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irqPend_r <= 1'b0;
			trapPend_r <= 1'b0;
			irqGrant_r <= 1'b0;
		end
		else
		begin
			irqGrant_r <= grantNow;
			// A new request in the grant cycle survives the clear.
			irqPend_r <= (irqPend_r && !(grantNow && !trapPend_r)) || irqReq; // RQ9
			trapPend_r <= (trapPend_r && !grantNow) || trapReq;
		end
	end

	// ==========================================================
	// Checks
	flags_fixed_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ5
		conditionFlags_r[7:5] == 3'b111)
		else $error("flags bits 7:5 not one");

	sp_window_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ16
		stackTopPointer_r[15:7] == STACK_HI)
		else $error("stack pointer left its window");

	sp_reset_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ17
		stackResetInstr |=> stackTopPointer_r == SP_RESET)
		else $error("stack reset did not load top");

	sp_push_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ15
		doPush && !stackResetInstr |=>
		stackTopPointer_r[6:0] == $past(spLow) - 7'h01 && memWe_r)
		else $error("push did not decrement pointer");

	half_carry_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ7
		aluUpd && aluIsAdd && !flagsWe && !restoreHit |=>
		conditionFlags_r[FLAG_HALF] == $past(aluHalf))
		else $error("half carry not taken from add");

	zero_neg_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ13
		aluUpd && !flagsWe && !restoreHit |=>
		conditionFlags_r[FLAG_ZERO] == ($past(aluResult) == 8'h00) &&
		conditionFlags_r[FLAG_NEG] == $past(aluResult[7]))
		else $error("zero or negative flag wrong");

	// The write strobe is registered, so the first save byte shows two edges on.
	entry_order_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ20
		ctxState_r == CTX_IDLE && intEntry |-> ##2
		memWe_r && memWdata_r == $past(instrCounter_r[7:0]) &&
		memAddr_r == $past(stackTopPointer_r) ##1 memWe_r [*4] ##1 !memWe_r)
		else $error("entry context save out of order");

	entry_mask_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ8
		ctxState_r == CTX_IDLE && intEntry |-> ##6 conditionFlags_r[FLAG_MASK])
		else $error("mask not set after entry");

	second_idx_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ3
		!secondIdxWe |=> $stable(secondIndex_r))
		else $error("second index changed without write");

	masked_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ9
		irqGrant_r |-> $past(trapPend_r) || !$past(conditionFlags_r[FLAG_MASK]))
		else $error("grant given while masked");

	return_mask_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ10
		ctxState_r == CTX_IDLE && intReturn && !intEntry |-> ##4
		!conditionFlags_r[FLAG_MASK])
		else $error("return left mask set");

endmodule

// ---- stack_ram_model.sv ----
// Stack RAM model standing behind the register set's memory port.
// Assumes core_clk only; read data is valid the cycle after memRe.
`timescale 1ns/1ps
module stack_ram_model
(
	input wire logic core_clk,
	input wire logic memWe,
	input wire logic memRe,
	input wire logic [15:0] memAddr,
	input wire logic [7:0] memWdata,
	output logic [7:0] memRdata
);
	// ==========================================================
	// Storage
	logic [7:0] mem [0:511];

	// Each write strobe stores one byte; old bytes are simply overwritten.
	always @(posedge core_clk)
	begin
		if (memWe)
			mem[memAddr[8:0]] <= memWdata;
	end

	// Data appears one cycle after the strobe and toggles otherwise,
	// so a design sampling stale data cannot pass by luck.
	initial memRdata = 8'h00;
	always @(posedge core_clk)
	begin
		if (memRe)
			memRdata <= mem[memAddr[8:0]];
		else
			memRdata <= ~memRdata;
	end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the core register set.
// Assumes the stack RAM model answers the memory port.
`timescale 1ns/1ps
module testbench;
	import cpu_regs_pkg::*;
	logic core_clk, arst_n, accWe, firstIdxWe, secondIdxWe, pcLoad, pcInc, flagsWe;
	logic aluUpd, aluIsAdd, aluHalf, carryUpd, aluCarry, carrySetInstr, carryClearInstr;
	logic maskSetInstr, maskClearInstr, stackResetInstr, spLowWe, pushReq, popReq;
	logic irqReq, trapReq, intEntry, intReturn, popValid_r, memWe_r, memRe_r, ctxBusy_r;
	logic irqGrant_r, seen;
	logic [7:0] accIn, idxIn, flagsIn, aluResult, spLowIn, pushData, memRdata;
	logic [7:0] workingAcc_r, firstIndex_r, secondIndex_r, conditionFlags_r;
	logic [7:0] popData_r, memWdata_r;
	logic [15:0] pcIn, instrCounter_r, stackTopPointer_r, memAddr_r;
	int mismatches = 0;
	int compares = 0;
	int n;

	// ==========================================================
	// Design and far side
	cpu_register_set cpu_register_set_inst (.core_clk, .arst_n, .accWe, .accIn,
		.firstIdxWe, .secondIdxWe, .idxIn, .pcLoad, .pcInc, .pcIn, .flagsWe, .flagsIn,
		.aluUpd, .aluIsAdd, .aluResult, .aluHalf, .carryUpd, .aluCarry, .carrySetInstr,
		.carryClearInstr, .maskSetInstr, .maskClearInstr, .stackResetInstr, .spLowWe,
		.spLowIn, .pushReq, .pushData, .popReq, .irqReq, .trapReq, .intEntry, .intReturn,
		.memRdata, .workingAcc_r, .firstIndex_r, .secondIndex_r, .instrCounter_r,
		.conditionFlags_r, .stackTopPointer_r, .popData_r, .popValid_r, .memWe_r,
		.memRe_r, .memAddr_r, .memWdata_r, .ctxBusy_r, .irqGrant_r);
	stack_ram_model stack_ram_model_inst (.core_clk(core_clk), .memWe(memWe_r),
		.memRe(memRe_r), .memAddr(memAddr_r), .memWdata(memWdata_r), .memRdata(memRdata));

	// Free-running 100 MHz core clock.
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ==========================================================
	// Helpers
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task wrap_up;
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// A sequencer that never goes idle counts as a failure and ends the run.
	task wait_idle;
		n = 0;
		while (ctxBusy_r !== 1'b0 && n < 12)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (ctxBusy_r !== 1'b0)
		begin
			chk("context busy", 16'h0000, ctxBusy_r);
			wrap_up;
		end
	endtask

	// Watches a fixed number of cycles for a grant pulse.
	task grant_seen(input int cyc);
		seen = 1'b0;
		repeat (cyc)
		begin
			@(posedge core_clk);
			#1;
			if (irqGrant_r === 1'b1)
				seen = 1'b1;
		end
	endtask

	// ==========================================================
	// Scenarios
	task test_regs;
		@(posedge core_clk);
		accWe <= 1; accIn <= 8'h5A; firstIdxWe <= 1; idxIn <= 8'h3C;
		pcLoad <= 1; pcIn <= 16'h12FE; flagsWe <= 1; flagsIn <= 8'h00;
		@(posedge core_clk);
		accWe <= 0; firstIdxWe <= 0; secondIdxWe <= 1; idxIn <= 8'hC3;
		pcLoad <= 0; pcInc <= 1; flagsWe <= 0;
		@(posedge core_clk);
		secondIdxWe <= 0; pcInc <= 0;
		#1;
		chk("acc", 16'h005A, workingAcc_r);
		chk("first index", 16'h003C, firstIndex_r);
		chk("second index", 16'h00C3, secondIndex_r);
		chk("counter", 16'h12FF, instrCounter_r);
		chk("flags load", 16'h00E0, conditionFlags_r);
	endtask

	// Walks the flags through add, non-add, carry and mask operations.
	task test_flags;
		@(posedge core_clk);
		aluUpd <= 1; aluIsAdd <= 1; aluHalf <= 1; aluResult <= 8'h80; carrySetInstr <= 1;
		@(posedge core_clk);
		aluIsAdd <= 0; aluHalf <= 0; aluResult <= 8'h00; carrySetInstr <= 0;
		carryClearInstr <= 1; maskSetInstr <= 1;
		#1 chk("flags add", 16'h00F5, conditionFlags_r);
		@(posedge core_clk);
		aluUpd <= 0; carryClearInstr <= 0; maskSetInstr <= 0; carryUpd <= 1; aluCarry <= 1;
		#1 chk("flags zero", 16'h00FA, conditionFlags_r);
		@(posedge core_clk);
		carryUpd <= 0; maskClearInstr <= 1; aluUpd <= 1; aluIsAdd <= 1; aluResult <= 8'h01;
		#1 chk("flags carry", 16'h00FB, conditionFlags_r);
		@(posedge core_clk);
		maskClearInstr <= 0; aluUpd <= 0; aluIsAdd <= 0;
		#1 chk("flags clear", 16'h00E1, conditionFlags_r);
	endtask

	task test_stack;
		@(posedge core_clk);
		stackResetInstr <= 1;
		@(posedge core_clk);
		stackResetInstr <= 0; pushReq <= 1; pushData <= 8'hA5;
		@(posedge core_clk);
		pushReq <= 0; popReq <= 1;
		#1;
		chk("push strobe", 16'h0001, memWe_r);
		chk("push addr", 16'h01FF, memAddr_r);
		chk("push data", 16'h00A5, memWdata_r);
		chk("sp push", 16'h01FE, stackTopPointer_r);
		@(posedge core_clk);
		#1;
		chk("pop strobe", 16'h0001, memRe_r);
		chk("pop addr", 16'h01FF, memAddr_r);
		@(posedge core_clk);
		popReq <= 0;
		#1 chk("sp wrap", 16'h0180, stackTopPointer_r);
		n = 0;
		while (popValid_r !== 1'b1 && n < 8)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (popValid_r !== 1'b1)
		begin
			chk("pop valid", 16'h0001, popValid_r);
			wrap_up;
		end
		chk("pop data", 16'h00A5, popData_r);
		@(posedge core_clk);
		spLowWe <= 1; spLowIn <= 8'h85;
		@(posedge core_clk);
		spLowWe <= 0; stackResetInstr <= 1;
		#1 chk("sp low", 16'h0185, stackTopPointer_r);
		@(posedge core_clk);
		stackResetInstr <= 0;
		#1 chk("sp reset", 16'h01FF, stackTopPointer_r);
	endtask

	// Saves a known context, clobbers it, then restores it.
	task test_context;
		@(posedge core_clk);
		accWe <= 1; accIn <= 8'h11; firstIdxWe <= 1; idxIn <= 8'h22;
		pcLoad <= 1; pcIn <= 16'h4455; flagsWe <= 1; flagsIn <= 8'h00;
		@(posedge core_clk);
		accWe <= 0; firstIdxWe <= 0; pcLoad <= 0; flagsWe <= 0; intEntry <= 1;
		@(posedge core_clk);
		intEntry <= 0;
		#1 wait_idle;
		// The last context byte reaches the RAM one edge after busy drops.
		@(posedge core_clk);
		#1;
		chk("save pcl", 16'h0055, stack_ram_model_inst.mem[9'h1FF]);
		chk("save pch", 16'h0044, stack_ram_model_inst.mem[9'h1FE]);
		chk("save idx", 16'h0022, stack_ram_model_inst.mem[9'h1FD]);
		chk("save acc", 16'h0011, stack_ram_model_inst.mem[9'h1FC]);
		chk("save flags", 16'h00E0, stack_ram_model_inst.mem[9'h1FB]);
		chk("sp entry", 16'h01FA, stackTopPointer_r);
		chk("mask entry", 16'h00E8, conditionFlags_r);
		@(posedge core_clk);
		accWe <= 1; accIn <= 8'h00; firstIdxWe <= 1; secondIdxWe <= 1; idxIn <= 8'h99;
		pcLoad <= 1; pcIn <= 16'h0000;
		@(posedge core_clk);
		accWe <= 0; firstIdxWe <= 0; secondIdxWe <= 0; pcLoad <= 0; intReturn <= 1;
		@(posedge core_clk);
		intReturn <= 0;
		#1 wait_idle;
		repeat (3) @(posedge core_clk);
		#1;
		chk("rest acc", 16'h0011, workingAcc_r);
		chk("rest idx", 16'h0022, firstIndex_r);
		chk("rest counter", 16'h4455, instrCounter_r);
		chk("rest flags", 16'h00E0, conditionFlags_r);
		chk("sp return", 16'h01FF, stackTopPointer_r);
		chk("second idx", 16'h0099, secondIndex_r);
	endtask

	task test_grant;
		@(posedge core_clk);
		maskSetInstr <= 1;
		@(posedge core_clk);
		maskSetInstr <= 0; irqReq <= 1;
		@(posedge core_clk);
		irqReq <= 0;
		grant_seen(10);
		chk("masked grant", 16'h0000, seen);
		@(posedge core_clk);
		maskClearInstr <= 1;
		@(posedge core_clk);
		maskClearInstr <= 0;
		grant_seen(4);
		chk("pending grant", 16'h0001, seen);
		@(posedge core_clk);
		maskSetInstr <= 1; trapReq <= 1;
		@(posedge core_clk);
		maskSetInstr <= 0; trapReq <= 0;
		grant_seen(4);
		chk("trap grant", 16'h0001, seen);
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		arst_n = 1'b0;
		{accWe, firstIdxWe, secondIdxWe, pcLoad, pcInc, flagsWe, aluUpd, aluIsAdd,
			aluHalf, carryUpd, aluCarry, carrySetInstr, carryClearInstr, maskSetInstr,
			maskClearInstr, stackResetInstr, spLowWe, pushReq, popReq, irqReq, trapReq,
			intEntry, intReturn} = '0;
		{accIn, idxIn, flagsIn, aluResult, spLowIn, pushData} = '0;
		pcIn = 16'h0000;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		#1;
		chk("flags reset", 16'h00E8, conditionFlags_r);
		chk("sp reset", 16'h01FF, stackTopPointer_r);
		test_regs;
		test_flags;
		test_stack;
		test_context;
		test_grant;
		wrap_up;
	end
endmodule
